// >>> rtl/cfs_fault_bank.sv
// converter fault status bank: sticky fault flags, phase records, serious
// overcurrent shutdown, interrupt, Avalon-MM slave
// assumes fault inputs are synchronous levels; sw_tick_i is a one-cycle
// pulse per switching clock cycle
`default_nettype none
// How it works
// - flyback primary overcurrent sets aux bit 4
// - supply input overvoltage sets aux bit 5
// - low-voltage bus undervoltage lockout sets aux bit 6
// - power-on reset sets aux bit 7
// - driver rail outside window sets regulator bit 0
// - regulator output overvoltage sets regulator bit 4
// - regulator output undervoltage sets regulator bit 5
// - first-level overcurrent sets bit 0, phase recorded
// - second-level overcurrent sets bit 1, phase recorded
// - negative overcurrent sets bit 2, phase recorded
// - bit 4 shows constant-current loop operation
// - average current limit fault sets bit 5
// - junction over 150 C sets bit 7
// - persistent second-level overcurrent: switches off, flag
// - persistent negative overcurrent: switches off, flag
// - flag registers byte wide, read/write, reset zero
module cfs_fault_bank (
    input wire logic clk_i, // 40 MHz clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic [cfs_pkg::ADDR_W-1:0] avs_address_i, // byte address
    input wire logic avs_read_i, // read request
    input wire logic avs_write_i, // write request
    input wire logic [cfs_pkg::DATA_W-1:0] avs_writedata_i, // write data
    input wire logic [3:0] avs_byteenable_i, // byte enables
    output logic [cfs_pkg::DATA_W-1:0] avs_readdata_o, // read data
    output logic avs_waitrequest_o, // stall
    input wire logic flyback_oc_i, // flyback primary overcurrent
    input wire logic vin_ov_i, // supply input overvoltage
    input wire logic lvbus_uvlo_i, // low-voltage bus below lockout
    input wire logic por_i, // power-on reset detected
    input wire logic drv_rail_bad_i, // driver supply outside window
    input wire logic ldo_ov_i, // regulator output overvoltage
    input wire logic ldo_uv_i, // regulator output undervoltage
    input wire logic [cfs_pkg::PHASES-1:0] oc1_i, // first-level oc per phase
    input wire logic [cfs_pkg::PHASES-1:0] oc2_i, // second-level oc per phase
    input wire logic [cfs_pkg::PHASES-1:0] noc_i, // negative oc per phase
    input wire logic ccl_active_i, // constant-current loop active
    input wire logic average_current_limit_protection_i, // average current limit fault
    input wire logic over_temp_i, // junction above 150 C
    input wire logic sw_tick_i, // switching cycle pulse
    output logic fets_off_o, // force all power switches off
    output logic irq_o // interrupt, high level
);
    import cfs_pkg::*;

    logic [7:0] aux_flags, reg_flags, oct_flags, ser_flags;
    logic [5:0] phase_oc1_noc, phase_oc2;
    logic [3:0] irq_mask, irq_stat;
    logic [1:0] oc2_run, noc_run;
    wire ack = !avs_waitrequest_o; // a request was taken last cycle

    wire [7:0] idx = avs_address_i[ADDR_W-1:2];
    wire wr_hit = avs_write_i && !ack && avs_byteenable_i[0];
    wire [7:0] wd = avs_writedata_i[7:0];
    wire wr_aux = wr_hit && idx == IDX_AUX_SUPPLY;
    wire wr_reg = wr_hit && idx == IDX_REGULATOR;
    wire wr_oct = wr_hit && idx == IDX_OC_THERMAL;
    wire wr_ser = wr_hit && idx == IDX_SERIOUS_OC;
    wire wr_p1 = wr_hit && idx == IDX_PHASE_OC1_NOC;
    wire wr_p2 = wr_hit && idx == IDX_PHASE_OC2;
    wire wr_msk = wr_hit && idx == IDX_IRQ_MASK;
    wire wr_ist = wr_hit && idx == IDX_IRQ_STATUS;

    wire any_oc1 = |oc1_i;
    wire any_oc2 = |oc2_i;
    wire any_noc = |noc_i;
    wire oc2_trip = any_oc2 && sw_tick_i && oc2_run == PERSIST_LIMIT;
    wire noc_trip = any_noc && sw_tick_i && noc_run == PERSIST_LIMIT;

    logic [7:0] aux_set, reg_set, oct_set, ser_set;
    always_comb begin
        aux_set = FLAG_RESET;
        aux_set[AUX_FLYBACK_OC] = flyback_oc_i;
        aux_set[AUX_VIN_OV] = vin_ov_i;
        aux_set[AUX_LVBUS_UVLO] = lvbus_uvlo_i;
        aux_set[AUX_POR] = por_i;
        reg_set = FLAG_RESET;
        reg_set[REG_DRV_RAIL_BAD] = drv_rail_bad_i;
        reg_set[REG_LDO_OV] = ldo_ov_i;
        reg_set[REG_LDO_UV] = ldo_uv_i;
        oct_set = FLAG_RESET;
        oct_set[OCT_OC1] = any_oc1;
        oct_set[OCT_OC2] = any_oc2;
        oct_set[OCT_NOC] = any_noc;
        oct_set[OCT_AVERAGE_CURRENT_LIMIT_PROTECTION] = average_current_limit_protection_i;
        oct_set[OCT_THERMAL] = over_temp_i;
        ser_set = FLAG_RESET;
        ser_set[SER_CONT_OC2] = oc2_trip;
        ser_set[SER_CONT_NOC] = noc_trip;
    end

    // write-one-to-clear masks; a write clears only the bits written as one
    wire [7:0] clr_aux = wr_aux ? wd : FLAG_RESET;
    wire [7:0] clr_reg = wr_reg ? wd : FLAG_RESET;
    wire [7:0] clr_oct = wr_oct ? wd : FLAG_RESET;
    wire [7:0] clr_ser = wr_ser ? wd : FLAG_RESET;
    wire [5:0] clr_p1 = wr_p1 ? wd[5:0] : PHASE_RESET;
    wire [5:0] clr_p2 = wr_p2 ? wd[5:0] : PHASE_RESET;

    // set wins over clear when event and write share a cycle
    wire [7:0] next_aux = (aux_flags & ~clr_aux | aux_set) & AUX_MASK;
    wire [7:0] next_reg = (reg_flags & ~clr_reg | reg_set) & REG_MASK;
    wire [7:0] oct_sticky = (oct_flags & ~clr_oct | oct_set) & OCT_MASK;
    // constant-current loop bit is a live indicator, not sticky
    wire [7:0] next_oct = {oct_sticky[7:5], ccl_active_i, oct_sticky[3:0]};
    wire [7:0] next_ser = (ser_flags & ~clr_ser | ser_set) & SER_MASK;
    // phase records: one bit per phase, sticky like the flags
    wire [5:0] next_p1 = phase_oc1_noc & ~clr_p1 | oc1_i | noc_i;
    wire [5:0] next_p2 = phase_oc2 & ~clr_p2 | oc2_i;

    wire [3:0] irq_ev = {|ser_set, |oct_set, |reg_set, |aux_set};
    wire [3:0] next_ist = irq_stat & ~(wr_ist ? wd[3:0] : IRQ_RESET) | irq_ev;

    // persistence counters count consecutive switching cycles with the fault present
    wire [1:0] next_oc2_run = !any_oc2 ? PERSIST_ZERO :
        (sw_tick_i && oc2_run != PERSIST_LIMIT) ? oc2_run + 2'h1 : oc2_run;
    wire [1:0] next_noc_run = !any_noc ? PERSIST_ZERO :
        (sw_tick_i && noc_run != PERSIST_LIMIT) ? noc_run + 2'h1 : noc_run;

    // shutdown holds while either serious flag is set
    wire next_fets_off = |next_ser;

    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = FLAG_RESET;
        unique case (idx)
            IDX_AUX_SUPPLY: rd_byte = aux_flags;
            IDX_REGULATOR: rd_byte = reg_flags;
            IDX_OC_THERMAL: rd_byte = oct_flags;
            IDX_SERIOUS_OC: rd_byte = ser_flags;
            IDX_PHASE_OC1_NOC: rd_byte = {2'h0, phase_oc1_noc};
            IDX_PHASE_OC2: rd_byte = {2'h0, phase_oc2};
            IDX_IRQ_MASK: rd_byte = {4'h0, irq_mask};
            IDX_IRQ_STATUS: rd_byte = {4'h0, irq_stat};
            default: rd_byte = FLAG_RESET;
        endcase
    end

    wire req = (avs_read_i || avs_write_i) && !ack;

    // flag registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_flags <= FLAG_RESET;
            reg_flags <= FLAG_RESET;
            oct_flags <= FLAG_RESET;
            ser_flags <= FLAG_RESET;
        end else begin
            aux_flags <= next_aux;
            reg_flags <= next_reg;
            oct_flags <= next_oct;
            ser_flags <= next_ser;
        end
    end

    // phase location records
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_oc1_noc <= PHASE_RESET;
            phase_oc2 <= PHASE_RESET;
        end else begin
            phase_oc1_noc <= next_p1;
            phase_oc2 <= next_p2;
        end
    end

    // interrupt mask, sticky status and level output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask <= IRQ_RESET;
            irq_stat <= IRQ_RESET;
            irq_o <= 1'b0;
        end else begin
            irq_mask <= wr_msk ? wd[3:0] : irq_mask;
            irq_stat <= next_ist;
            irq_o <= |(next_ist & irq_mask);
        end
    end

    // persistence counters and switch shutdown
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oc2_run <= PERSIST_ZERO;
            noc_run <= PERSIST_ZERO;
            fets_off_o <= 1'b0;
        end else begin
            oc2_run <= next_oc2_run;
            noc_run <= next_noc_run;
            fets_off_o <= next_fets_off;
        end
    end

    // waitrequest drops for exactly the cycle after a request is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !req;
        end
    end

    // read data holds the last value read
    wire [DATA_W-1:0] next_rdata = {24'h000000, rd_byte};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            avs_readdata_o <= '0;
        end else if (req && avs_read_i) begin
            avs_readdata_o <= next_rdata;
        end
    end

    chk_oc2_shutdown: assert property (@(posedge clk_i) disable iff (rst_i)
        oc2_trip |=> ser_flags[SER_CONT_OC2] && fets_off_o)
        else $error("persistent oc2 did not shut switches off");
    chk_noc_shutdown: assert property (@(posedge clk_i) disable iff (rst_i)
        noc_trip |=> ser_flags[SER_CONT_NOC] && fets_off_o)
        else $error("persistent noc did not shut switches off");
    chk_no_early_trip: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ser_flags[SER_CONT_OC2]) |-> $past(oc2_run) == PERSIST_LIMIT)
        else $error("oc2 shutdown before persistence");
    chk_aux_por_set: assert property (@(posedge clk_i) disable iff (rst_i)
        por_i |=> aux_flags[AUX_POR])
        else $error("por flag not set");
    chk_aux_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        aux_flags[AUX_VIN_OV] && !wr_aux |=> aux_flags[AUX_VIN_OV])
        else $error("vin flag lost without write");
    chk_oc1_phase: assert property (@(posedge clk_i) disable iff (rst_i)
        oc1_i != PHASE_RESET |=> oct_flags[OCT_OC1] && (phase_oc1_noc & $past(oc1_i)) != 0)
        else $error("oc1 phase not recorded");
    chk_oc2_phase: assert property (@(posedge clk_i) disable iff (rst_i)
        oc2_i != PHASE_RESET |=> oct_flags[OCT_OC2] && (phase_oc2 & $past(oc2_i)) != 0)
        else $error("oc2 phase not recorded");
    chk_ccl_live: assert property (@(posedge clk_i) disable iff (rst_i)
        oct_flags[OCT_CCL] == $past(ccl_active_i))
        else $error("ccl indicator stale");
    chk_thermal_set: assert property (@(posedge clk_i) disable iff (rst_i)
        over_temp_i |=> oct_flags[OCT_THERMAL])
        else $error("thermal flag not set");
    chk_rail_set: assert property (@(posedge clk_i) disable iff (rst_i)
        drv_rail_bad_i |=> reg_flags[REG_DRV_RAIL_BAD])
        else $error("driver rail flag not set");
    chk_reset_zero: assert property (@(posedge clk_i)
        $past(rst_i) |-> aux_flags == FLAG_RESET && ser_flags == FLAG_RESET)
        else $error("flags not zero after reset");
    chk_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("waitrequest not released one cycle");

    // flag setting per event
    chk_flyback_set: assert property (@(posedge clk_i) disable iff (rst_i)
        flyback_oc_i |=> aux_flags[AUX_FLYBACK_OC])
        else $error("flyback flag not set");

    chk_vin_ov_set: assert property (@(posedge clk_i) disable iff (rst_i)
        vin_ov_i |=> aux_flags[AUX_VIN_OV])
        else $error("vin flag not set");

    chk_uvlo_set: assert property (@(posedge clk_i) disable iff (rst_i)
        lvbus_uvlo_i |=> aux_flags[AUX_LVBUS_UVLO])
        else $error("uvlo flag not set");

    chk_ldo_ov_set: assert property (@(posedge clk_i) disable iff (rst_i)
        ldo_ov_i |=> reg_flags[REG_LDO_OV])
        else $error("ldo ov flag not set");

    chk_ldo_uv_set: assert property (@(posedge clk_i) disable iff (rst_i)
        ldo_uv_i |=> reg_flags[REG_LDO_UV])
        else $error("ldo uv flag not set");

    chk_noc_phase: assert property (@(posedge clk_i) disable iff (rst_i)
        noc_i != PHASE_RESET |=> oct_flags[OCT_NOC] && (phase_oc1_noc & $past(noc_i)) != 0)
        else $error("noc phase not recorded");

    chk_average_current_limit_protection_set: assert property (@(posedge clk_i) disable iff (rst_i)
        average_current_limit_protection_i |=> oct_flags[OCT_AVERAGE_CURRENT_LIMIT_PROTECTION])
        else $error("average_current_limit_protection flag not set");

    // persistence and shutdown
    chk_noc_no_early: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ser_flags[SER_CONT_NOC]) |-> $past(noc_run) == PERSIST_LIMIT)
        else $error("noc shutdown before persistence");

    chk_fets_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        fets_off_o == (ser_flags != FLAG_RESET))
        else $error("shutdown not tied to serious flags");

    chk_oc2_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !oc2_trip && !ser_flags[SER_CONT_OC2] |=> !ser_flags[SER_CONT_OC2])
        else $error("oc2 serious flag set without trip");

    chk_noc_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !noc_trip && !ser_flags[SER_CONT_NOC] |=> !ser_flags[SER_CONT_NOC])
        else $error("noc serious flag set without trip");

    chk_oc2_run_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        !any_oc2 |=> oc2_run == PERSIST_ZERO)
        else $error("oc2 run not cleared");

    chk_noc_run_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        !any_noc |=> noc_run == PERSIST_ZERO)
        else $error("noc run not cleared");

    chk_reg_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        reg_flags[REG_LDO_OV] && !wr_reg |=> reg_flags[REG_LDO_OV])
        else $error("ldo flag lost without write");

    chk_oct_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        oct_flags[OCT_THERMAL] && !wr_oct |=> oct_flags[OCT_THERMAL])
        else $error("thermal flag lost without write");

    chk_ser_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        ser_flags[SER_CONT_OC2] && !wr_ser |=> ser_flags[SER_CONT_OC2])
        else $error("serious flag lost without write");

    chk_clear_works: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_aux && wd[AUX_POR] && !por_i |=> !aux_flags[AUX_POR])
        else $error("por flag not cleared");

    chk_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_aux && flyback_oc_i |=> aux_flags[AUX_FLYBACK_OC])
        else $error("clear beat a live event");

    chk_aux_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
        (aux_flags & ~AUX_MASK) == FLAG_RESET && (reg_flags & ~REG_MASK) == FLAG_RESET)
        else $error("reserved aux or reg bit set");

    chk_oct_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
        (oct_flags & ~OCT_MASK) == FLAG_RESET && (ser_flags & ~SER_MASK) == FLAG_RESET)
        else $error("reserved oct or ser bit set");

    chk_por_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !por_i && !wr_aux |=> aux_flags[AUX_POR] == $past(aux_flags[AUX_POR]))
        else $error("por flag moved without cause");

    chk_rail_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !drv_rail_bad_i && !reg_flags[REG_DRV_RAIL_BAD] |=> !reg_flags[REG_DRV_RAIL_BAD])
        else $error("rail flag set without cause");

    chk_therm_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !over_temp_i && !oct_flags[OCT_THERMAL] |=> !oct_flags[OCT_THERMAL])
        else $error("thermal flag set without cause");

    chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == ((irq_stat & $past(irq_mask)) != IRQ_RESET))
        else $error("irq level wrong");

    chk_irq_event: assert property (@(posedge clk_i) disable iff (rst_i)
        por_i |=> irq_stat[0])
        else $error("irq status not set");

    chk_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
        req && avs_read_i |=> avs_readdata_o == {24'h000000, $past(rd_byte)})
        else $error("read data wrong");

    chk_read_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(req && avs_read_i) |=> avs_readdata_o == $past(avs_readdata_o))
        else $error("read data moved");

    chk_wait_reset: assert property (@(posedge clk_i)
        $past(rst_i) |-> avs_waitrequest_o)
        else $error("waitrequest low after reset");


    cov_oc2_trip: cover property (@(posedge clk_i) disable iff (rst_i) oc2_trip);
    cov_noc_trip: cover property (@(posedge clk_i) disable iff (rst_i) noc_trip);
    cov_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
    cov_clear: cover property (@(posedge clk_i) disable iff (rst_i) wr_aux && wd[AUX_POR]);
    cov_ccl_on: cover property (@(posedge clk_i) disable iff (rst_i) $rose(oct_flags[OCT_CCL]));
endmodule
`default_nettype wire

// >>> rtl/cfs_pkg.sv
// package for the converter fault status bank: register map, bit positions, constants
// assumes one 40 MHz clock and a 32-bit Avalon-MM slave port
`default_nettype none
package cfs_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int FLAG_W = 8;
    // printed offsets are register indexes; byte address is four times the index
    localparam logic [7:0] IDX_AUX_SUPPLY = 8'hD3;
    localparam logic [7:0] IDX_REGULATOR = 8'hD4;
    localparam logic [7:0] IDX_OC_THERMAL = 8'hD5;
    localparam logic [7:0] IDX_SERIOUS_OC = 8'hD6;
    localparam logic [7:0] IDX_PHASE_OC1_NOC = 8'hD9;
    localparam logic [7:0] IDX_PHASE_OC2 = 8'hDA;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hE0;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hE1;
    // aux supply flags
    localparam int AUX_FLYBACK_OC = 4;
    localparam int AUX_VIN_OV = 5;
    localparam int AUX_LVBUS_UVLO = 6;
    localparam int AUX_POR = 7;
    // regulator flags
    localparam int REG_DRV_RAIL_BAD = 0;
    localparam int REG_LDO_OV = 4;
    localparam int REG_LDO_UV = 5;
    // overcurrent and thermal flags
    localparam int OCT_OC1 = 0;
    localparam int OCT_OC2 = 1;
    localparam int OCT_NOC = 2;
    localparam int OCT_CCL = 4;
    localparam int OCT_AVERAGE_CURRENT_LIMIT_PROTECTION = 5;
    localparam int OCT_THERMAL = 7;
    // serious overcurrent flags
    localparam int SER_CONT_OC2 = 2;
    localparam int SER_CONT_NOC = 4;
    // writable bit masks; reserved bits read zero
    localparam logic [7:0] AUX_MASK = 8'hF0;
    localparam logic [7:0] REG_MASK = 8'h31;
    localparam logic [7:0] OCT_MASK = 8'hB7;
    localparam logic [7:0] SER_MASK = 8'h14;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam int PHASES = 6;
    localparam logic [5:0] PHASE_RESET = 6'h00;
    // interrupt status bits, one per flag register
    localparam int IRQ_W = 4;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    // persistence: more than three switching cycles
    localparam logic [1:0] PERSIST_LIMIT = 2'h3;
    localparam logic [1:0] PERSIST_ZERO = 2'h0;
endpackage
`default_nettype wire

// >>> sim/cfs_fault_bank_tb_top.sv
// self-checking bench for the fault status bank
// assumes the bus master model drives the register port
`default_nettype none
module cfs_fault_bank_tb_top import cfs_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [11:0] flt = 12'h000;
    logic constant_current_loop = 1'b0;
    logic tick = 1'b0;
    logic [5:0] ph = 6'h08;
    wire logic [ADDR_W-1:0] addr;
    wire logic rd_en, wr_en, wait_req, fets_off, irq;
    wire logic [DATA_W-1:0] wdata, rdata;
    wire logic [3:0] be;
    logic [31:0] rd;
    int num_errors = 0;
    int check_count = 0;
    logic [7:0] tbl_idx [12];
    int tbl_bit [12];
    always #12.5 clk_i = ~clk_i;
    cfs_mcu_model u_mcu (.clk_i(clk_i), .avs_address_o(addr), .avs_read_o(rd_en),
        .avs_write_o(wr_en), .avs_writedata_o(wdata), .avs_byteenable_o(be),
        .avs_readdata_i(rdata), .avs_waitrequest_i(wait_req));
    cfs_fault_bank dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(addr),
        .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
        .flyback_oc_i(flt[0]), .vin_ov_i(flt[1]), .lvbus_uvlo_i(flt[2]), .por_i(flt[3]),
        .drv_rail_bad_i(flt[4]), .ldo_ov_i(flt[5]), .ldo_uv_i(flt[6]),
        .oc1_i(flt[7] ? ph : 6'h00), .oc2_i(flt[8] ? ph : 6'h00),
        .noc_i(flt[9] ? ph : 6'h00), .average_current_limit_protection_i(flt[10]), .over_temp_i(flt[11]),
        .ccl_active_i(constant_current_loop), .sw_tick_i(tick), .fets_off_o(fets_off), .irq_o(irq));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        u_mcu.xfer(1'b0, idx, 8'h00, rd);
        check(what, rd, {24'h000000, exp});
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        u_mcu.xfer(1'b1, idx, d, rd);
    endtask
    task automatic pulse_tick();
        tick <= 1'b1;
        cyc(1);
        tick <= 1'b0;
        cyc(1);
    endtask
    task automatic t_reset();
        rd_chk("aux", IDX_AUX_SUPPLY, 8'h00);
        rd_chk("reg", IDX_REGULATOR, 8'h00);
        rd_chk("oct", IDX_OC_THERMAL, 8'h00);
        rd_chk("ser", IDX_SERIOUS_OC, 8'h00);
        rd_chk("unmapped", 8'h10, 8'h00);
        check("fets_off", fets_off, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_flags();
        logic [7:0] fb;
        logic [7:0] pidx;
        for (int i = 0; i < 12; i++) begin
            fb = 8'h01 << tbl_bit[i];
            pidx = (i == 8) ? IDX_PHASE_OC2 : IDX_PHASE_OC1_NOC;
            flt[i] <= 1'b1;
            cyc(1);
            flt[i] <= 1'b0;
            cyc(2);
            if (i < 4) rd_chk("flag", tbl_idx[i], fb);
            else if (i < 7) rd_chk("flag", tbl_idx[i], fb);
            else rd_chk("flag", tbl_idx[i], fb);
            if (i >= 7 && i <= 9) begin
                rd_chk("phase", pidx, 8'h08);
                wr(pidx, 8'h08);
            end
            wr(tbl_idx[i], fb);
            rd_chk("cleared", tbl_idx[i], 8'h00);
        end
        flt[0] <= 1'b1;
        cyc(2);
        wr(IDX_AUX_SUPPLY, 8'h10);
        rd_chk("set wins", IDX_AUX_SUPPLY, 8'h10);
        flt[0] <= 1'b0;
        cyc(1);
        wr(IDX_AUX_SUPPLY, 8'h10);
        constant_current_loop <= 1'b1;
        cyc(2);
        wr(IDX_OC_THERMAL, 8'h10);
        rd_chk("ccl on", IDX_OC_THERMAL, 8'h10);
        constant_current_loop <= 1'b0;
        cyc(2);
        rd_chk("ccl off", IDX_OC_THERMAL, 8'h00);
        $display("test flags done");
    endtask
    task automatic t_persist(input int f, input logic [7:0] sbit, input logic [7:0] obit);
        ph <= 6'h21;
        flt[f] <= 1'b1;
        cyc(1);
        repeat (3) pulse_tick();
        flt[f] <= 1'b0;
        cyc(1);
        flt[f] <= 1'b1;
        repeat (3) pulse_tick();
        check("fets early", fets_off, 1'b0);
        rd_chk("ser early", IDX_SERIOUS_OC, 8'h00);
        pulse_tick();
        cyc(1);
        check("fets trip", fets_off, 1'b1);
        rd_chk("ser trip", IDX_SERIOUS_OC, sbit);
        flt[f] <= 1'b0;
        cyc(1);
        wr(IDX_SERIOUS_OC, sbit);
        wr(IDX_OC_THERMAL, obit);
        wr(IDX_PHASE_OC1_NOC, 8'h21);
        wr(IDX_PHASE_OC2, 8'h21);
        check("fets release", fets_off, 1'b0);
        $display("test persist done");
    endtask
    task automatic t_irq();
        wr(IDX_IRQ_STATUS, 8'h0F);
        wr(IDX_IRQ_MASK, 8'h01);
        flt[3] <= 1'b1;
        cyc(1);
        flt[3] <= 1'b0;
        cyc(3);
        check("irq set", irq, 1'b1);
        wr(IDX_IRQ_MASK, 8'h00);
        check("irq masked", irq, 1'b0);
        wr(IDX_IRQ_MASK, 8'h01);
        check("irq unmasked", irq, 1'b1);
        u_mcu.por_service();
        rd_chk("por cleared", IDX_AUX_SUPPLY, 8'h00);
        wr(IDX_IRQ_STATUS, 8'h01);
        cyc(1);
        check("irq cleared", irq, 1'b0);
        $display("test irq done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        tbl_idx = '{IDX_AUX_SUPPLY, IDX_AUX_SUPPLY, IDX_AUX_SUPPLY, IDX_AUX_SUPPLY,
            IDX_REGULATOR, IDX_REGULATOR, IDX_REGULATOR, IDX_OC_THERMAL, IDX_OC_THERMAL,
            IDX_OC_THERMAL, IDX_OC_THERMAL, IDX_OC_THERMAL};
        tbl_bit = '{AUX_FLYBACK_OC, AUX_VIN_OV, AUX_LVBUS_UVLO, AUX_POR, REG_DRV_RAIL_BAD,
            REG_LDO_OV, REG_LDO_UV, OCT_OC1, OCT_OC2, OCT_NOC, OCT_AVERAGE_CURRENT_LIMIT_PROTECTION, OCT_THERMAL};
        cyc(2);
        rst_i <= 1'b0;
        cyc(1);
        t_reset();
        t_flags();
        t_persist(8, 8'h04, 8'h02);
        t_persist(9, 8'h10, 8'h04);
        t_irq();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// >>> sim/cfs_mcu_model.sv
// bus master model of the microcontroller that reads and clears the fault bank
// assumes one clock shared with the bank and calls made just after a rising edge
`default_nettype none
module cfs_mcu_model import cfs_pkg::*; (
    input wire logic clk_i, // bank clock
    output logic [ADDR_W-1:0] avs_address_o, // byte address
    output logic avs_read_o, // read request
    output logic avs_write_o, // write request
    output logic [DATA_W-1:0] avs_writedata_o, // write data
    output logic [3:0] avs_byteenable_o, // byte enables
    input wire logic [DATA_W-1:0] avs_readdata_i, // read data
    input wire logic avs_waitrequest_i // stall
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        avs_address_o = '0;
        avs_read_o = 1'b0;
        avs_write_o = 1'b0;
        avs_writedata_o = '0;
        avs_byteenable_o = 4'h0;
    end
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wdata,
                        output logic [31:0] rdata);
        avs_address_o <= {idx, 2'b00};
        avs_write_o <= wr;
        avs_read_o <= !wr;
        avs_writedata_o <= {24'h000000, wdata};
        avs_byteenable_o <= 4'hF;
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_i !== 1'b0);
        rdata = avs_readdata_i;
        avs_read_o <= 1'b0;
        avs_write_o <= 1'b0;
        // released lines stop showing the old value
        avs_address_o <= ~avs_address_o;
        avs_writedata_o <= ~avs_writedata_o;
        @(posedge clk_i);
    endtask
    // read the aux supply flags, then clear the power-on flag if it is set
    task automatic por_service();
        logic [31:0] d;
        xfer(1'b0, IDX_AUX_SUPPLY, 8'h00, d);
        if (d[AUX_POR] === 1'b1) begin
            xfer(1'b1, IDX_AUX_SUPPLY, 8'h80, d);
        end
    endtask
endmodule
`default_nettype wire
